// ### srr_defines.svh
// Timing, opcode and address-field constants for the security area read block
`ifndef SRR_DEFINES_SVH
`define SRR_DEFINES_SVH
`define SRR_OPCODE        8'h48
`define SRR_OP_BITS       6'd8
`define SRR_ADDR_END      6'd32
`define SRR_DUMMY_END     6'd40
`define SRR_AREA_MIN      4'h1
`define SRR_AREA_MAX      4'h3
`define SRR_HIGH_ZERO     8'h00
`define SRR_MID_ZERO      4'h0
`define SRR_MEM_WORDS     1024
`define SRR_FILL_BYTE     8'hff
`endif

// ### srr_pkg.sv
// Types shared by the security area read block
package srr_pkg;
	typedef enum logic [1:0]
	{
		SRR_IDLE  = 2'b00,
		SRR_CMD   = 2'b01,
		SRR_SHIFT = 2'b11,
		SRR_DROP  = 2'b10
	} srr_state_t;

	typedef struct packed
	{
		logic sclk;
		logic cs_n;
		logic din;
	} srr_pins_t;

	typedef struct packed
	{
		logic       wr_en;
		logic [9:0] wr_addr;
		logic [7:0] wr_data;
	} srr_wr_t;
endpackage

// ### srr_mem.sv
// Storage array for the three security areas, one read port, one write port
`timescale 1ns/1ps
`include "srr_defines.svh"
module srr_mem
(
	input  wire logic           clk,
	input  wire srr_pkg::srr_wr_t wr,
	input  wire logic [9:0]     rd_addr,
	output logic [7:0]          rd_data
);
	logic [7:0] mem [0:`SRR_MEM_WORDS-1];

	// ============================================================
	// Write port and registered read
	always_ff @(posedge clk)
	begin
		if (wr.wr_en)
			mem[wr.wr_addr] <= wr.wr_data;
		rd_data <= mem[rd_addr];
	end
endmodule

// ### srr_read.sv
// Read handler for the one-time-programmable security areas over serial link
`timescale 1ns/1ps
`include "srr_defines.svh"
// Function
// - Opcode and address bits are sampled on rising serial clock edges.
// - After the dummy clocks the addressed byte leaves on falling edges, MSB first.
// - After each byte the pointer advances by one while clocks keep coming.
// - Past the last byte of the area the pointer wraps to the first byte.
// - Raising chip select ends the instruction and stops the output.
// - The read is ignored while a program, erase or write cycle holds busy; the code samples busy only once, as the frame starts.
// - Address bits 23-16 and 11-8 are zero, 15-12 pick area one to three, 7-0 the byte.
// - Busy reads one for the whole self-timed cycle and zero once it ends.
module srr_read
(
	input  wire logic             clk,
	input  wire logic             rst,
	input  wire logic             sclk,
	input  wire logic             cs_n,
	input  wire logic             serial_in_pin,
	input  wire logic             cycle_busy,
	input  wire srr_pkg::srr_wr_t wr,
	output logic                  serial_out,
	output logic                  serial_out_oe,
	output logic                  busy_flag
);
	// ============================================================
	// State record
	typedef struct packed
	{
		// Two-stage pin synchronisers and the clock delay for edges
		srr_pkg::srr_pins_t s1;
		srr_pkg::srr_pins_t s2;
		logic               sclk_d;
		// Frame sequencing
		srr_pkg::srr_state_t st;
		logic [5:0]         cnt;
		// Header fields as they arrive
		logic [7:0]         op;
		logic [23:0]        addr;
		logic [1:0]         area;
		logic [7:0]         ptr;
		// Output shifter
		logic [7:0]         shreg;
		logic [2:0]         bitn;
		// Frame verdict
		logic               rejected;
		// Serial output driver and its enable
		logic               dout;
		logic               oe;
		// Status copy
		logic               busy;
	} srr_reg_t;

	// ============================================================
	// Working signals
	srr_reg_t    st_r;
	srr_reg_t    st_nxt;
	// Storage read port
	logic [9:0]  rd_addr;
	logic [7:0]  rd_data;
	// Serial clock edges seen this cycle
	logic        rise;
	logic        fall;
	// Header words including the synchronised data bit seen this cycle
	logic [7:0]  op_full;
	logic [23:0] addr_full;

	// ============================================================
	// Address decode helper
	// A bad field anywhere refuses the whole frame
	function automatic logic addr_ok(input logic [23:0] a);
		addr_ok = (a[23:16] == `SRR_HIGH_ZERO) && (a[11:8] == `SRR_MID_ZERO)
			&& (a[15:12] >= `SRR_AREA_MIN) && (a[15:12] <= `SRR_AREA_MAX);
	endfunction

	// Byte store for the areas
	// Index is area then byte; area zero is never shifted out
	srr_mem u_mem
	(
		.clk     (clk),
		.wr      (wr),
		.rd_addr (rd_addr),
		.rd_data (rd_data)
	);

	// ============================================================
	// Edge detection on the synchronised serial clock
	// Each clock phase must last one system clock or edges are lost
	// Deselect is seen through the same two stages as the clock
	assign rise = st_r.s2.sclk & ~st_r.sclk_d;
	assign fall = ~st_r.s2.sclk & st_r.sclk_d;

	// Shift-in view used by the header decode
	assign op_full = {st_r.op[6:0], st_r.s2.din};
	assign addr_full = {st_r.addr[22:0], st_r.s2.din};

	// Storage is read at the live pointer
	assign rd_addr = {st_r.area, st_r.ptr};

	// ============================================================
	// Next-state logic
	always_comb
	begin
		// Hold by default
		st_nxt = st_r;
		// Pins through two flip-flops, then the edge delay
		st_nxt.s1 = '{sclk: sclk, cs_n: cs_n, din: serial_in_pin};
		st_nxt.s2 = st_r.s1;
		st_nxt.sclk_d = st_r.s2.sclk;
		// Status copy of the self-timed cycle
		st_nxt.busy = cycle_busy;
		if (st_r.s2.cs_n)
		begin
			// Deselected: abandon everything
			// Fields stay; the next header reloads them
			st_nxt.st = srr_pkg::SRR_IDLE;
			st_nxt.oe = 1'b0;
			st_nxt.cnt = 6'd0;
		end
		else
		begin
			case (st_r.st)
				srr_pkg::SRR_IDLE:
				begin
					// Busy is judged once per frame, so a cycle ending
					// mid-header cannot let a half-seen command through
					st_nxt.st = srr_pkg::SRR_CMD;
					st_nxt.cnt = 6'd0;
					st_nxt.rejected = st_r.busy;
					st_nxt.oe = 1'b0;
				end
				srr_pkg::SRR_CMD:
				begin
					// Count rising edges through the header
					if (rise)
					begin
						st_nxt.cnt = st_r.cnt + 6'd1;
						// Opcode then address, MSB first
						if (st_r.cnt < `SRR_OP_BITS)
							st_nxt.op = op_full;
						else if (st_r.cnt < `SRR_ADDR_END)
							st_nxt.addr = addr_full;
						// Wrong opcode, or busy at the start: sit the frame out
						if (st_r.cnt == `SRR_OP_BITS - 6'd1
							&& (op_full != `SRR_OPCODE || st_r.rejected))
							st_nxt.st = srr_pkg::SRR_DROP;
						// Full address known: check it and load the pointer
						if (st_r.cnt == `SRR_ADDR_END - 6'd1)
						begin
							if (!addr_ok(addr_full))
								st_nxt.st = srr_pkg::SRR_DROP;
							st_nxt.area = addr_full[13:12];
							st_nxt.ptr = addr_full[7:0];
						end
						// Last dummy clock: data starts on the next fall
						if (st_r.cnt == `SRR_DUMMY_END - 6'd1)
						begin
							st_nxt.st = srr_pkg::SRR_SHIFT;
							st_nxt.bitn = 3'd0;
						end
					end
				end
				srr_pkg::SRR_SHIFT:
				begin
					// Next bit on each falling edge
					if (fall)
					begin
						st_nxt.oe = 1'b1;
						// Byte boundary: take the byte read one clock after the
						// pointer settled, then step the pointer; it wraps in the area
						if (st_r.bitn == 3'd0)
						begin
							st_nxt.dout = rd_data[7];
							st_nxt.shreg = {rd_data[6:0], 1'b0};
							st_nxt.ptr = st_r.ptr + 8'd1;
						end
						else
						begin
							// Inside a byte: shift on
							st_nxt.dout = st_r.shreg[7];
							st_nxt.shreg = {st_r.shreg[6:0], 1'b0};
						end
						st_nxt.bitn = st_r.bitn + 3'd1;
					end
				end
				srr_pkg::SRR_DROP:
				begin
					// Refused frame: keep the line released until deselect
					st_nxt.oe = 1'b0;
				end
				default:
				begin
					// Unused code: recover to idle
					st_nxt.st = srr_pkg::SRR_IDLE;
				end
			endcase
		end
	end

	// ============================================================
	// State register
	// One register for the whole record; reset is asynchronous
	always_ff @(posedge clk or posedge rst)
	begin
		if (rst)
		begin
			// Sync stages park at the idle pin levels: no false edge
			st_r <= '0;
			st_r.s1 <= 3'b010;
			st_r.s2 <= 3'b010;
		end
		else
			st_r <= st_nxt;
	end

	// ============================================================
	// Outputs straight from the state register
	// Enable falls three clocks after chip select rises
	assign serial_out = st_r.dout;
	assign serial_out_oe = st_r.oe;
	assign busy_flag = st_r.busy;
endmodule

// ### srr_monitor.sv
// Port checker for the security area read block
`timescale 1ns/1ps
module srr_monitor
(
	input wire logic clk,
	input wire logic rst,
	input wire logic sclk,
	input wire logic cs_n,
	input wire logic cycle_busy,
	input wire logic serial_out,
	input wire logic serial_out_oe,
	input wire logic busy_flag
);
	default clocking @(posedge clk); endclocking
	default disable iff (rst);
	busy_copy_a: assert property (busy_flag == $past(cycle_busy)) else $error("busy");
	idle_off_a: assert property (cs_n[*5] |-> !serial_out_oe) else $error("idle");
	cmd_off_a: assert property ($fell(cs_n) |=> !serial_out_oe[*8]) else $error("cmd");
	oe_drop_a: assert property ($fell(serial_out_oe) |-> cs_n) else $error("drop");
	first_bit_a: assert property ($rose(serial_out_oe) |-> !cs_n && !sclk
		&& !$past(cs_n, 8)) else $error("start");
	bit_hold_a: assert property ((serial_out_oe && sclk)[*2] |-> $stable(serial_out))
		else $error("hold");
	fall_only_a: assert property ($changed(serial_out) && serial_out_oe |-> !sclk)
		else $error("edge");
	busy_ref_a: assert property ($fell(cs_n) && cycle_busy ##1 cycle_busy[*4]
		|=> !serial_out_oe[*8]) else $error("busy read");
endmodule
bind srr_read srr_monitor i_srr_monitor (.clk, .rst, .sclk, .cs_n, .cycle_busy,
	.serial_out, .serial_out_oe, .busy_flag);

// ### srr_host.sv
// Serial host model issuing framed security area reads
`timescale 1ns/1ps
module srr_host
(
	output logic      sclk,
	output logic      cs_n,
	output logic      din,
	input  wire logic dq
);
	logic [7:0] got[$];
	// Clock parked low and deselected between frames
	initial
	begin
		{sclk, cs_n, din} = 3'b010;
	end
	// Opcode, address, dummies, then n bytes sampled late in the high phase
	task automatic rd(input logic [7:0] op, input logic [23:0] a, input int n);
		logic [39:0] c;
		logic [7:0]  b;
		c = {op, a, 8'h00};
		got = {};
		cs_n = 0;
		for (int i = 0; i < 40 + 8 * n; i++)
		begin
			din = (i < 40) ? c[39 - i] : ~din;
			#80 sclk = 1;
			#79 b = {b[6:0], dq};
			if (i >= 40 && i % 8 == 7)
				got.push_back(b);
			#1 sclk = 0;
		end
		#80 cs_n = 1;
		#400;
	endtask
endmodule

// ### tb.sv
// Self-checking bench for the security area read block
`timescale 1ns/1ps
`define CHK(a, b) begin compares++; if ((a) !== (b)) begin fail_count++; \
	$display("mismatch %0t got %h want %h", $time, a, b); end end
module tb;
	logic             clk, rst, cycle_busy, serial_out, serial_out_oe, busy_flag;
	logic             sclk, cs_n, din;
	srr_pkg::srr_wr_t wr;
	logic [7:0]       mem[1024];
	logic [31:0]      bad[6] = '{32'h03001000, 32'h48011000, 32'h48001100,
		32'h48000000, 32'h48004000, 32'h48001000};
	int               fail_count, compares, seed, oe_seen, oe_base;
	wire              dq = serial_out_oe ? serial_out : 1'bz;
	srr_read i_srr_read (.clk, .rst, .sclk, .cs_n, .serial_in_pin(din), .cycle_busy, .wr,
		.serial_out, .serial_out_oe, .busy_flag);
	srr_host i_srr_host (.sclk, .cs_n, .din, .dq);
	// Clock and hang guard
	initial
	begin
		clk = 0;
		forever #10 clk = ~clk;
	end
	initial
	begin
		#400000 fail_count++;
		stop_test;
	end
	// Count cycles with the output enabled
	always @(posedge clk)
		if (serial_out_oe === 1'b1)
			oe_seen <= oe_seen + 1;
	task stop_test;
		$display("compares %0d fails %0d", compares, fail_count);
		if (fail_count == 0 && compares > 0)
			$display("Testbench passed");
		else
			$display("Testbench failed");
		$finish;
	endtask
	// Fill, wrapping reads of each area, then refused reads
	initial
	begin
		{seed, rst, cycle_busy, wr} = {32'haaef, 2'b10, 19'h0};
		repeat (6) @(posedge clk);
		#2 rst = 0;
		for (int i = 256; i < 1025; i++)
		begin
			@(posedge clk);
			mem[i % 1024] = 8'($random(seed));
			#2 wr = (i < 1024) ? {1'b1, 10'(i), mem[i]} : 19'h0;
		end
		for (int a = 1; a < 4; a++)
		begin
			i_srr_host.rd(8'h48, {12'(a), 12'h0fe}, 4);
			for (int k = 0; k < 4; k++)
				`CHK(i_srr_host.got[k], mem[{2'(a), 8'(254 + k)}])
			$display("read %0d done", a);
		end
		for (int t = 0; t < 6; t++)
		begin
			@(posedge clk);
			#2 cycle_busy = (t == 5);
			repeat (3) @(posedge clk);
			#2 oe_base = oe_seen;
			`CHK(busy_flag, cycle_busy)
			i_srr_host.rd(bad[t][31:24], bad[t][23:0], 1);
			`CHK(oe_seen, oe_base)
			$display("refuse %0d done", t);
		end
		stop_test;
	end
endmodule
